// ---- verilog/wdog_pkg.sv ----
/*
 two-stage watchdog package: register offsets, field positions,
 reset values, id field defaults, bus carrier types.
 assumes a plain strobe register port with 12-bit word offsets.
*/
package wdog_pkg;
    localparam int          ADDR_W        = 13;
    // address bit 12 selects the frame: 0 refresh, 1 control
    localparam int          FRAME_BIT     = 12;
    localparam logic [11:0] OFF_REFRESH   = 12'h000;
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_OFS_LO    = 12'h008;
    localparam logic [11:0] OFF_OFS_HI    = 12'h00c;
    localparam logic [11:0] OFF_CMP_LO    = 12'h010;
    localparam logic [11:0] OFF_CMP_HI    = 12'h014;
    localparam logic [11:0] OFF_IDENT     = 12'hfcc;
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_A1_BIT   = 1;
    localparam int          CTRL_A2_BIT   = 2;
    localparam int          OFS_W         = 48;
    localparam int          OFS_HI_W      = 16;
    localparam logic        EN_RST        = 1'b0;
    localparam logic [47:0] OFS_RST       = 48'h0;
    localparam logic [63:0] CMP_RST       = 64'h0;
    // identification fields; product, revision, implementer arbitrary
    localparam logic [11:0] ID_PRODUCT    = 12'h001;
    localparam logic [3:0]  ID_ARCH       = 4'h1;
    localparam logic [3:0]  ID_REVISION   = 4'h0;
    localparam logic [3:0]  ID_CONT_CODE  = 4'h0;
    localparam logic [6:0]  ID_IDENT_CODE = 7'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic first_alarm;
        logic second_alarm;
    } alarm_t;
endpackage

// ---- verilog/two_stage_watchdog.sv ----
/*
 two-stage watchdog timed against a 64-bit system counter.
 assumes counter input synchronous to clk; plain strobe register port,
 read data one cycle after the read strobe.
*/
//
// Behaviour
// - alarm event when counter exceeds compare
// - explicit refresh loads counter plus offset
// - timeout reloads compare while first alarm off
// - timeout keeps compare once first alarm on
// - refresh, offset, control writes refresh explicitly
// - explicit refresh clears alarms; timeout keeps them
// - enabled timeout raises first alarm
// - timeout with first alarm raises second
// - alarms hold until refresh, reset, disable
// - disable beats refresh beats timeout
// - offset 48 bits, zero extended
// - compare writes load directly, highest priority
// - 32-bit little-endian word registers
// - two frames: refresh and control
// - refresh write restarts; reads zero
// - alarm status bits read-only, upper zero
// - bit 0 enable, reset clears
// - offset split low word, high 16 bits
// - compare readable as low, high words
// - read-only identification at 0xfcc
// - implementer code in low twelve bits
`timescale 1ns/10ps
`default_nettype none
module two_stage_watchdog (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    clk_en,
    // system counter
    input  wire logic [63:0]             sys_count,
    // register port
    input  wire logic [wdog_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    // alarms
    output logic                         first_alarm,
    output logic                         second_alarm
);
    import wdog_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode

    reg_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
                   rd: reg_rd};

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic ctl,
                                 input logic [11:0] off);
        hit = (a[FRAME_BIT] == ctl) && (a[11:0] == off);
    endfunction

    logic wr_refresh;
    logic wr_ctrl;
    logic wr_ofs_lo;
    logic wr_ofs_hi;
    logic wr_cmp_lo;
    logic wr_cmp_hi;
    logic explicit_refresh;
    logic timeout;

    assign wr_refresh = req.wr && hit(req.addr, 1'b0, OFF_REFRESH);
    assign wr_ctrl    = req.wr && hit(req.addr, 1'b1, OFF_CTRL);
    assign wr_ofs_lo  = req.wr && hit(req.addr, 1'b1, OFF_OFS_LO);
    assign wr_ofs_hi  = req.wr && hit(req.addr, 1'b1, OFF_OFS_HI);
    assign wr_cmp_lo  = req.wr && hit(req.addr, 1'b1, OFF_CMP_LO);
    assign wr_cmp_hi  = req.wr && hit(req.addr, 1'b1, OFF_CMP_HI);

    assign explicit_refresh = wr_refresh || wr_ctrl || wr_ofs_lo
                              || wr_ofs_hi;

    ////////////////////////////////////////////////////////////////////////
    // state

    logic        enable_ff;
    logic [47:0] offset_ff;
    logic [63:0] compare_ff;
    alarm_t      alarm_ff;
    logic [31:0] rdata_ff;

    assign timeout = sys_count > compare_ff;

    // enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enable_ff <= EN_RST;
        end else if (clk_en && wr_ctrl) begin
            enable_ff <= req.wdata[CTRL_EN_BIT];
        end
    end

    // period offset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            offset_ff <= OFS_RST;
        end else if (clk_en) begin
            if (wr_ofs_lo) begin
                offset_ff[31:0] <= req.wdata;
            end
            if (wr_ofs_hi) begin
                offset_ff[OFS_W-1:32] <= req.wdata[OFS_HI_W-1:0];
            end
        end
    end

    // compare value
    logic [63:0] reload_sum;
    assign reload_sum = sys_count + {16'h0, offset_ff};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            compare_ff <= CMP_RST;
        end else if (clk_en) begin
            if (wr_cmp_lo || wr_cmp_hi) begin
                if (wr_cmp_lo) begin
                    compare_ff[31:0] <= req.wdata;
                end
                if (wr_cmp_hi) begin
                    compare_ff[63:32] <= req.wdata;
                end
            end else if (explicit_refresh) begin
                compare_ff <= reload_sum;
            end else if (timeout && !alarm_ff.first_alarm) begin
                compare_ff <= reload_sum;
            end
            // timeout with first alarm set keeps compare
        end
    end

    // alarms
    logic nxt_enable;
    assign nxt_enable = wr_ctrl ? req.wdata[CTRL_EN_BIT] : enable_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alarm_ff <= '0;
        end else if (clk_en) begin
            if (!nxt_enable) begin
                alarm_ff <= '0;
            end else if (explicit_refresh) begin
                alarm_ff <= '0;
            end else if (timeout) begin
                if (!alarm_ff.first_alarm) begin
                    alarm_ff.first_alarm <= 1'b1;
                end else begin
                    alarm_ff.second_alarm <= 1'b1;
                end
            end
        end
    end

    assign first_alarm  = alarm_ff.first_alarm;
    assign second_alarm = alarm_ff.second_alarm;

    ////////////////////////////////////////////////////////////////////////
    // read path

    logic [31:0] ident_word;
    assign ident_word = {ID_PRODUCT, ID_ARCH, ID_REVISION,
                         ID_CONT_CODE, 1'b0, ID_IDENT_CODE};

    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0;
        if (req.addr[11:0] == OFF_IDENT) begin
            nxt_rdata = ident_word;
        end else if (req.addr[FRAME_BIT]) begin
            unique case (req.addr[11:0])
                OFF_CTRL: begin
                    nxt_rdata[CTRL_EN_BIT] = enable_ff;
                    nxt_rdata[CTRL_A1_BIT] = alarm_ff.first_alarm;
                    nxt_rdata[CTRL_A2_BIT] = alarm_ff.second_alarm;
                end
                OFF_OFS_LO: nxt_rdata = offset_ff[31:0];
                OFF_OFS_HI: nxt_rdata = {16'h0, offset_ff[47:32]};
                OFF_CMP_LO: nxt_rdata = compare_ff[31:0];
                OFF_CMP_HI: nxt_rdata = compare_ff[63:32];
                default:    nxt_rdata = 32'h0;
            endcase
        end
        // refresh word reads zero
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 32'h0;
        end else if (clk_en) begin
            rdata_ff <= req.rd ? nxt_rdata : 32'h0;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule // two_stage_watchdog
`default_nettype wire

// ---- bench/sys_counter_model.sv ----
/*
 system counter model: holds, steps by one, or loads a value.
 assumes the bench loads it only while the watchdog is disabled.
*/
`timescale 1ns/10ps
`default_nettype none
module sys_counter_model (
    // clock
    input  wire logic        clk,
    // control
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [63:0] load_val,
    // count
    output logic      [63:0] count
);
    always_ff @(posedge clk) begin
        if (load)
            count <= load_val;
        else if (run)
            count <= count + 64'h1;
    end
endmodule // sys_counter_model
`default_nettype wire

// ---- bench/wdog_chk_assertions.sv ----
/*
 port assertions for the two-stage watchdog.
 assumes bind to its ports; one clock, async active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module wdog_chk (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        rstn,
    input wire logic                        clk_en,
    // register port
    input wire logic [wdog_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [31:0]                 reg_rdata,
    // alarms
    input wire logic                        first_alarm,
    input wire logic                        second_alarm
);
    import wdog_pkg::*;
    logic rd;
    logic ex;
    assign rd = clk_en && reg_rd;
    assign ex = clk_en && reg_wr && (reg_addr == 13'h0000
        || reg_addr[12] && reg_addr[11:0] inside {12'h0, 12'h8, 12'hc});
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not idle");
    a_status_read: assert property (
        rd && reg_addr == 13'h1000 |=> reg_rdata[31:1]
            == {29'h0, $past(second_alarm), $past(first_alarm)})
        else $error("status bits wrong");
    a_refresh_zero: assert property (
        rd && reg_addr == 13'h0000 |=> reg_rdata == 32'h0)
        else $error("refresh read not zero");
    a_ident_value: assert property (
        rd && reg_addr[11:0] == OFF_IDENT |=> reg_rdata == {ID_PRODUCT,
            ID_ARCH, ID_REVISION, ID_CONT_CODE, 1'b0, ID_IDENT_CODE})
        else $error("ident wrong");
    a_ofs_hi_zero: assert property (
        rd && reg_addr == 13'h100c |=> reg_rdata[31:16] == 16'h0)
        else $error("offset high upper bits set");
    a_refresh_clears: assert property (
        ex |=> !first_alarm && !second_alarm)
        else $error("alarm survives refresh");
    a_first_holds: assert property (
        first_alarm && !ex |=> first_alarm)
        else $error("first alarm dropped");
    a_second_holds: assert property (
        second_alarm && !ex |=> second_alarm)
        else $error("second alarm dropped");
    a_second_order: assert property (
        $rose(second_alarm) |-> $past(first_alarm) && first_alarm)
        else $error("second alarm without first");
    a_first_clean: assert property (
        $rose(first_alarm) |-> !second_alarm)
        else $error("first alarm rose with second");
    c_first: cover property ($rose(first_alarm));
    c_second: cover property ($rose(second_alarm));
    c_ident: cover property (rd && reg_addr[11:0] == OFF_IDENT);
endmodule // wdog_chk
bind two_stage_watchdog wdog_chk wdog_chk_i (.clk(clk), .rstn(rstn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_alarm(first_alarm), .second_alarm(second_alarm));
`default_nettype wire

// ---- bench/two_stage_watchdog_bench.sv ----
/*
 bench for the two-stage watchdog: counter model, read queue.
 assumes package, design and checker compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module two_stage_watchdog_bench;
    import wdog_pkg::*;
    logic clk = 0, rstn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic run = 0, load = 1, rd_q = 0, first_alarm, second_alarm;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, id, q[$];
    logic [63:0] sys_count, load_val = 64'h1_ffff_fff0, c;
    logic [12:0] rst_a[5] = '{13'h1000, 13'h1008, 13'h100c, 0, 13'h1004};
    int n_mismatch = 0, tests_run = 0, cyc = 0, n;
    always #25 clk = ~clk;
    sys_counter_model sys_counter_model_i (.clk(clk), .run(run),
        .load(load), .load_val(load_val), .count(sys_count));
    two_stage_watchdog two_stage_watchdog_i (.clk(clk), .rstn(rstn),
        .clk_en(clk_en), .sys_count(sys_count), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .first_alarm(first_alarm),
        .second_alarm(second_alarm));
    ////////////////////////////////////////////////////////////////////////
    task end_of_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task acc(input logic w, input logic [12:0] a, input logic [31:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w)
            q.push_back(d);
        @(posedge clk);
    endtask
    task idle;
        reg_wr <= 0;
        reg_rd <= 0;
        @(posedge clk);
    endtask
    task wait_al(input logic s);
        for (int i = 0; i < 300 && !(s ? second_alarm : first_alarm); i++)
            @(negedge clk);
        @(posedge clk);
    endtask
    // read data checked the cycle after the strobe
    always @(posedge clk) begin
        rd_q <= reg_rd;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    always @(negedge clk) begin
        if (rd_q) begin
            tests_run++;
            if (reg_rdata !== q[0]) begin
                n_mismatch++;
                $display("mismatch %0t %h %h", $time, reg_rdata, q[0]);
            end
            void'(q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(46));
        n = 16 + $urandom % 32;
        id = {ID_PRODUCT, ID_ARCH, ID_REVISION, ID_CONT_CODE, 1'b0,
            ID_IDENT_CODE};
        repeat (16) @(posedge clk);
        rstn <= 1;
        load <= 0;
        foreach (rst_a[i]) acc(0, rst_a[i], 32'h0);
        acc(0, 13'h0fcc, id);
        acc(1, 13'h1008, n);
        acc(1, 13'h100c, 32'habcd_0000);
        acc(1, 13'h1000, 32'h7);
        c = load_val + n;
        acc(0, 13'h100c, 32'h0);
        acc(0, 13'h1000, 32'h1);
        acc(0, 13'h1010, c[31:0]);
        acc(0, 13'h1014, c[63:32]);
        idle;
        run <= 1;
        wait_al(0);
        c = c + n + 1;
        acc(0, 13'h1000, 32'h3);
        acc(0, 13'h1010, c[31:0]);
        acc(0, 13'h1014, c[63:32]);
        idle;
        wait_al(1);
        acc(0, 13'h1000, 32'h7);
        acc(0, 13'h1010, c[31:0]);
        acc(1, 13'h1000, 32'h0);
        acc(0, 13'h1000, 32'h0);
        acc(1, 13'h1000, 32'h1);
        acc(1, 13'h0000, $urandom);
        acc(0, 13'h1000, 32'h1);
        acc(1, 13'h1000, 32'h0);
        load_val <= 64'h5;
        load <= 1;
        idle;
        load <= 0;
        c = {$urandom | 32'h8000_0000, $urandom};
        acc(1, 13'h1010, c[31:0]);
        acc(1, 13'h1014, c[63:32]);
        acc(1, 13'h1fcc, 32'hffff_ffff);
        acc(0, 13'h1010, c[31:0]);
        acc(0, 13'h1014, c[63:32]);
        acc(0, 13'h1fcc, id);
        clk_en <= 0;
        acc(1, 13'h1008, 32'h0);
        clk_en <= 1;
        acc(0, 13'h1008, n);
        idle;
        idle;
        end_of_test;
    end
endmodule // two_stage_watchdog_bench
`default_nettype wire
